// ===== registered_bus_transceiver.v
// Two-direction registered transceiver between buses A and B.
// Assumes all pins are asynchronous to clk_in; the pad ring resolves the
// two-way buses from the output enables.
`timescale 1ns/1ps
`include "xcvr_defs.vh"

module registered_bus_transceiver #(
   parameter INVERT = `XCVR_INVERT_DEFAULT
) (
   input wire clk_in,
   input wire nrst_in,
   input wire [`XCVR_WIDTH-1:0] bus_a_in,
   output wire [`XCVR_WIDTH-1:0] bus_a_out,
   output wire bus_a_oe_out,
   input wire [`XCVR_WIDTH-1:0] bus_b_in,
   output wire [`XCVR_WIDTH-1:0] bus_b_out,
   output wire bus_b_oe_out,
   input wire clock_a_to_b_in,
   input wire clock_b_to_a_in,
   input wire load_enable_n_a_to_b_in,
   input wire load_enable_n_b_to_a_in,
   input wire drive_enable_n_a_to_b_in,
   input wire drive_enable_n_b_to_a_in,
   output wire a_to_b_ready_out,
   output wire b_to_a_ready_out,
   output wire a_to_b_overflow_out,
   output wire b_to_a_overflow_out,
   output wire [`XCVR_FIFO_CW-1:0] a_to_b_level_out,
   output wire [`XCVR_FIFO_CW-1:0] b_to_a_level_out
);

   // ==========================================
   // Helpers
   function [`XCVR_WIDTH-1:0] polarity;
      input [`XCVR_WIDTH-1:0] value;
      begin
         polarity = value ^ {`XCVR_WIDTH{INVERT[0]}}; // R6 R7
      end
   endfunction

   // ==========================================
   // Pin synchronisers
   wire [`XCVR_SYNC_W-1:0] pins_raw;
   reg [`XCVR_SYNC_W-1:0] sync1_reg;
   reg [`XCVR_SYNC_W-1:0] sync2_reg;
   reg clk_ab_last_reg;
   reg clk_ba_last_reg;

   assign pins_raw = {bus_a_in, bus_b_in, clock_a_to_b_in, clock_b_to_a_in,
      load_enable_n_a_to_b_in, load_enable_n_b_to_a_in,
      drive_enable_n_a_to_b_in, drive_enable_n_b_to_a_in};

   // Enables reset to their inactive high level so nothing drives after reset
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sync1_reg <= `XCVR_SYNC_RESET;
         sync2_reg <= `XCVR_SYNC_RESET;
         clk_ab_last_reg <= 1'b0;
         clk_ba_last_reg <= 1'b0;
      end else begin
         sync1_reg <= pins_raw;
         sync2_reg <= sync1_reg;
         clk_ab_last_reg <= sync2_reg[`XCVR_SB_CLK_AB];
         clk_ba_last_reg <= sync2_reg[`XCVR_SB_CLK_BA];
      end
   end

   wire [`XCVR_WIDTH-1:0] a_sync;
   wire [`XCVR_WIDTH-1:0] b_sync;
   wire rise_ab;
   wire rise_ba;
   wire load_n_ab;
   wire load_n_ba;
   wire drive_n_ab;
   wire drive_n_ba;

   assign a_sync = sync2_reg[`XCVR_SB_A_LSB +: `XCVR_WIDTH];
   assign b_sync = sync2_reg[`XCVR_SB_B_LSB +: `XCVR_WIDTH];
   assign rise_ab = sync2_reg[`XCVR_SB_CLK_AB] && !clk_ab_last_reg;
   assign rise_ba = sync2_reg[`XCVR_SB_CLK_BA] && !clk_ba_last_reg;
   assign load_n_ab = sync2_reg[`XCVR_SB_LOAD_AB];
   assign load_n_ba = sync2_reg[`XCVR_SB_LOAD_BA];
   assign drive_n_ab = sync2_reg[`XCVR_SB_DRIVE_AB];
   assign drive_n_ba = sync2_reg[`XCVR_SB_DRIVE_BA];

   // ==========================================
   // Capture into the per-direction queues
   // Each direction owns its clock, load enable and drive enable
   wire cap_ab;
   wire cap_ba;
   wire ab_in_ready;
   wire ba_in_ready;

   assign cap_ab = rise_ab && !load_n_ab; // R2 R5
   assign cap_ba = rise_ba && !load_n_ba; // R2 R4 R5
   assign a_to_b_ready_out = ab_in_ready;
   assign b_to_a_ready_out = ba_in_ready;

   wire ab_head_valid;
   wire ba_head_valid;
   wire [`XCVR_WIDTH-1:0] ab_head;
   wire [`XCVR_WIDTH-1:0] ba_head;
   wire ab_pop;
   wire ba_pop;

   // Queue drains only while its bus is released, so a driven value never
   // changes under the far side; captures meanwhile pile up and back-pressure
   assign ab_pop = ab_head_valid && drive_n_ab;
   assign ba_pop = ba_head_valid && drive_n_ba;

   xcvr_fifo #(
      .WIDTH(`XCVR_WIDTH),
      .DEPTH(`XCVR_FIFO_DEPTH),
      .AW(`XCVR_FIFO_AW),
      .CW(`XCVR_FIFO_CW)
   ) u_fifo_ab (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .in_valid_in(cap_ab),
      .in_ready_out(ab_in_ready),
      .in_data_in(a_sync),
      .out_valid_out(ab_head_valid),
      .out_ready_in(drive_n_ab),
      .out_data_out(ab_head),
      .level_out(a_to_b_level_out)
   );

   xcvr_fifo #(
      .WIDTH(`XCVR_WIDTH),
      .DEPTH(`XCVR_FIFO_DEPTH),
      .AW(`XCVR_FIFO_AW),
      .CW(`XCVR_FIFO_CW)
   ) u_fifo_ba (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .in_valid_in(cap_ba),
      .in_ready_out(ba_in_ready),
      .in_data_in(b_sync),
      .out_valid_out(ba_head_valid),
      .out_ready_in(drive_n_ba),
      .out_data_out(ba_head),
      .level_out(b_to_a_level_out)
   );

   // ==========================================
   // Holding registers and output drive
   reg [`XCVR_WIDTH-1:0] ab_hold_reg;
   reg [`XCVR_WIDTH-1:0] ba_hold_reg;
   reg b_oe_reg;
   reg a_oe_reg;
   reg ab_ovf_reg;
   reg ba_ovf_reg;

   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ab_hold_reg <= `XCVR_DATA_RESET;
         ba_hold_reg <= `XCVR_DATA_RESET;
         b_oe_reg <= 1'b0;
         a_oe_reg <= 1'b0;
         ab_ovf_reg <= 1'b0;
         ba_ovf_reg <= 1'b0;
      end else begin
         if (ab_pop) begin
            ab_hold_reg <= polarity(ab_head); // R1 R6 R7
         end
         if (ba_pop) begin
            ba_hold_reg <= polarity(ba_head); // R1 R4
         end
         b_oe_reg <= !drive_n_ab; // R3 R8
         a_oe_reg <= !drive_n_ba; // R3 R4 R8
         // A capture that meets a full queue is dropped and flagged for one cycle
         ab_ovf_reg <= cap_ab && !ab_in_ready;
         ba_ovf_reg <= cap_ba && !ba_in_ready;
      end
   end

   assign bus_b_out = ab_hold_reg; // R8
   assign bus_b_oe_out = b_oe_reg;
   assign bus_a_out = ba_hold_reg; // R8
   assign bus_a_oe_out = a_oe_reg;
   assign a_to_b_overflow_out = ab_ovf_reg;
   assign b_to_a_overflow_out = ba_ovf_reg;

endmodule

// ===== xcvr_defs.vh
// Constants shared by the registered bus transceiver and its queue.
// Assumes one 10 MHz system clock and an active-low asynchronous reset.
//
// Operation
// [R1] Two separate 8-bit holding registers, one per direction between buses A and B.
// [R2] A register loads its input bus on its clock rise only while load enable is low; the code loads it from a queue only while the far bus is released.
// [R3] Stored value drives the far bus only while drive enable is low, else released.
// [R4] A-to-B and B-to-A paths behave identically in capture and drive.
// [R5] Each direction has its own clock, load enable and drive enable inputs.
// [R6] Non-inverting build passes captured bits to the output bus unchanged.
// [R7] Inverting build drives the complement; a build parameter picks the variant.
// [R8] A-to-B uses its controls and drives B; B-to-A likewise drives A.
`ifndef XCVR_DEFS_VH
`define XCVR_DEFS_VH

// ==========================================
// Widths and depths
`define XCVR_WIDTH 8
`define XCVR_FIFO_DEPTH 16
`define XCVR_FIFO_AW 4
`define XCVR_FIFO_CW 5

// ==========================================
// Reset values and variants
`define XCVR_DATA_RESET 8'h00
`define XCVR_INVERT_DEFAULT 1'b0

// ==========================================
// Synchronised pin vector layout
`define XCVR_SYNC_W 22
// Clocks reset low to match the edge detector, enables reset high (inactive)
`define XCVR_SYNC_RESET 22'h00000F
`define XCVR_SB_A_LSB 14
`define XCVR_SB_B_LSB 6
`define XCVR_SB_CLK_AB 5
`define XCVR_SB_CLK_BA 4
`define XCVR_SB_LOAD_AB 3
`define XCVR_SB_LOAD_BA 2
`define XCVR_SB_DRIVE_AB 1
`define XCVR_SB_DRIVE_BA 0

`endif

// ===== xcvr_fifo.v
// Small synchronous queue with a registered read port.
// Assumes writer and reader share clk_in; reset is asynchronous, active low.
`timescale 1ns/1ps
`include "xcvr_defs.vh"

module xcvr_fifo #(
   parameter WIDTH = `XCVR_WIDTH,
   parameter DEPTH = `XCVR_FIFO_DEPTH,
   parameter AW = `XCVR_FIFO_AW,
   parameter CW = `XCVR_FIFO_CW
) (
   input wire clk_in,
   input wire nrst_in,
   input wire in_valid_in,
   output wire in_ready_out,
   input wire [WIDTH-1:0] in_data_in,
   output wire out_valid_out,
   input wire out_ready_in,
   output wire [WIDTH-1:0] out_data_out,
   output wire [CW-1:0] level_out
);

   // ==========================================
   // Storage
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_reg;
   reg [AW-1:0] rd_ptr_reg;
   reg [CW-1:0] count_reg;
   reg [WIDTH-1:0] head_reg;
   reg head_valid_reg;

   wire push;
   wire pop_out;
   wire refill;

   // Head register is an extra slot, so total capacity is DEPTH plus one
   assign in_ready_out = (count_reg != DEPTH[CW-1:0]);
   assign push = in_valid_in && in_ready_out;
   assign pop_out = head_valid_reg && out_ready_in;
   assign refill = (count_reg != {CW{1'b0}}) && (!head_valid_reg || pop_out);
   assign out_valid_out = head_valid_reg;
   assign out_data_out = head_reg;
   assign level_out = count_reg;

   always @(posedge clk_in) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data_in;
      end
   end

   // ==========================================
   // Pointers and head register
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         wr_ptr_reg <= {AW{1'b0}};
         rd_ptr_reg <= {AW{1'b0}};
         count_reg <= {CW{1'b0}};
         head_reg <= {WIDTH{1'b0}};
         head_valid_reg <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (refill) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
            head_reg <= mem[rd_ptr_reg];
            head_valid_reg <= 1'b1;
         end else if (pop_out) begin
            head_valid_reg <= 1'b0;
         end
         if (push && !refill) begin
            count_reg <= count_reg + 1'b1;
         end else if (refill && !push) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end

endmodule

// ===== registered_bus_transceiver_properties.sv
// Pin-level checker for the registered bus transceiver.
// Assumes it is bound to the top module with every port matched by name.
`timescale 1ns/1ps
`include "xcvr_defs.vh"
module registered_bus_transceiver_properties (
   input wire clk_in,
   input wire nrst_in,
   input wire [`XCVR_WIDTH-1:0] bus_a_out,
   input wire bus_a_oe_out,
   input wire [`XCVR_WIDTH-1:0] bus_b_out,
   input wire bus_b_oe_out,
   input wire drive_enable_n_a_to_b_in,
   input wire drive_enable_n_b_to_a_in,
   input wire a_to_b_ready_out,
   input wire b_to_a_ready_out,
   input wire a_to_b_overflow_out,
   input wire b_to_a_overflow_out
);
   // ==========================================
   // Drive enables: two sync flops and the enable register
   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   b_drive_on_a: assert property ($fell(drive_enable_n_a_to_b_in) |->
      !bus_b_oe_out [*3] ##1 bus_b_oe_out) else $error("bus B drive start off");
   b_drive_off_a: assert property ($rose(drive_enable_n_a_to_b_in) |->
      bus_b_oe_out [*3] ##1 !bus_b_oe_out) else $error("bus B release off");
   a_drive_on_a: assert property ($fell(drive_enable_n_b_to_a_in) |->
      !bus_a_oe_out [*3] ##1 bus_a_oe_out) else $error("bus A drive start off");
   a_drive_off_a: assert property ($rose(drive_enable_n_b_to_a_in) |->
      bus_a_oe_out [*3] ##1 !bus_a_oe_out) else $error("bus A release off");
   // ==========================================
   // A driven value never changes mid-drive; an overflow flag is a one-cycle pulse after a not-ready capture
   b_value_hold_a: assert property (bus_b_oe_out && $past(bus_b_oe_out) |->
      $stable(bus_b_out)) else $error("bus B value moved while driven");
   a_value_hold_a: assert property (bus_a_oe_out && $past(bus_a_oe_out) |->
      $stable(bus_a_out)) else $error("bus A value moved while driven");
   ab_drop_pulse_a: assert property (a_to_b_overflow_out |->
      !$past(a_to_b_ready_out) ##1 !a_to_b_overflow_out) else $error("bad A to B drop");
   ba_drop_pulse_a: assert property (b_to_a_overflow_out |->
      !$past(b_to_a_ready_out) ##1 !b_to_a_overflow_out) else $error("bad B to A drop");
   cover property (a_to_b_overflow_out);
   cover property ($rose(bus_a_oe_out));
   cover property (bus_b_oe_out ##1 $changed(bus_b_out));
endmodule

// ===== bus_partner.sv
// Far-side model of buses A and B, resolving each wire from all drivers.
// Where the bench and the device both drive a side, the bench value wins.
`timescale 1ns/1ps
module bus_partner (
   input wire clk_in,
   input wire [7:0] a_val_in,
   input wire a_drv_in,
   input wire [7:0] b_val_in,
   input wire b_drv_in,
   input wire [7:0] dev_a_in,
   input wire dev_a_oe_in,
   input wire [7:0] dev_b_in,
   input wire dev_b_oe_in,
   output wire [7:0] wire_a_out,
   output wire [7:0] wire_b_out
);
   reg [7:0] last_a_reg = 8'h00;
   reg [7:0] last_b_reg = 8'h00;
   // ==========================================
   // No pull resistor: a floating bus toggles so stale data never matches
   always @(posedge clk_in) begin
      last_a_reg <= wire_a_out;
      last_b_reg <= wire_b_out;
   end
   assign wire_a_out = a_drv_in ? a_val_in : dev_a_oe_in ? dev_a_in : ~last_a_reg;
   assign wire_b_out = b_drv_in ? b_val_in : dev_b_oe_in ? dev_b_in : ~last_b_reg;
endmodule

// ===== registered_bus_transceiver_test.sv
// Self-checking bench: plain and inverting builds share all inputs.
// Assumes the partner model resolves both buses.
`timescale 1ns/1ps
module registered_bus_transceiver_test;
   reg clk_in = 1'b0;
   reg nrst_in = 1'b0;
   reg clock_a_to_b_in = 1'b0;
   reg clock_b_to_a_in = 1'b0;
   reg load_enable_n_a_to_b_in = 1'b1;
   reg load_enable_n_b_to_a_in = 1'b1;
   reg drive_enable_n_a_to_b_in = 1'b1;
   reg drive_enable_n_b_to_a_in = 1'b1;
   reg [7:0] pa_v = 8'h00;
   reg [7:0] pb_v = 8'h00;
   reg pa_d = 1'b0;
   reg pb_d = 1'b0;
   wire [7:0] bus_a_in, bus_b_in, bus_a_out, bus_b_out, ia, ib;
   wire bus_a_oe_out, bus_b_oe_out, a_to_b_ready_out, b_to_a_ready_out;
   wire a_to_b_overflow_out, b_to_a_overflow_out;
   wire [4:0] a_to_b_level_out, b_to_a_level_out;
   integer err_total = 0, n_compared = 0, cyc = 0, ovf = 0, i;
   always #50 clk_in = ~clk_in;
   registered_bus_transceiver uut (.*);
   registered_bus_transceiver #(.INVERT(1'b1)) uut_inv (.*, .bus_a_out(ia), .bus_b_out(ib),
      .bus_a_oe_out(), .bus_b_oe_out(), .a_to_b_ready_out(), .b_to_a_ready_out(),
      .a_to_b_overflow_out(), .b_to_a_overflow_out(), .a_to_b_level_out(),
      .b_to_a_level_out());
   bus_partner far_side (.clk_in(clk_in), .a_val_in(pa_v), .a_drv_in(pa_d), .b_val_in(pb_v),
      .b_drv_in(pb_d), .dev_a_in(bus_a_out), .dev_a_oe_in(bus_a_oe_out), .dev_b_in(bus_b_out),
      .dev_b_oe_in(bus_b_oe_out), .wire_a_out(bus_a_in), .wire_b_out(bus_b_in));
   // ==========================================
   // Shared tasks
   task give_verdict;
      begin
         $display("compared %0d, mismatches %0d", n_compared, err_total);
         if (err_total == 0 && n_compared > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   task chk(input [7:0] got, input [7:0] exp);
      begin
         n_compared = n_compared + 1;
         if (got !== exp) begin
            err_total = err_total + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task tick(input integer n);
      repeat (n) @(posedge clk_in);
   endtask
   // Pins held 4 cycles before and after each clock rise: the sync needs 3
   task cap(input d, input [7:0] v, input ld);
      begin
         pa_v <= v;
         pb_v <= v;
         pa_d <= !d;
         pb_d <= d;
         load_enable_n_a_to_b_in <= d | ld;
         load_enable_n_b_to_a_in <= !d | ld;
         tick(4);
         clock_a_to_b_in <= !d;
         clock_b_to_a_in <= d;
         tick(4);
         clock_a_to_b_in <= 1'b0;
         clock_b_to_a_in <= 1'b0;
         pa_d <= 1'b0;
         pb_d <= 1'b0;
         load_enable_n_a_to_b_in <= 1'b1;
         load_enable_n_b_to_a_in <= 1'b1;
         tick(4);
      end
   endtask
   task show(input d, input [7:0] exp);
      begin
         drive_enable_n_a_to_b_in <= d;
         drive_enable_n_b_to_a_in <= !d;
         tick(6);
         chk(d ? bus_a_out : bus_b_out, exp);
         chk(d ? ia : ib, ~exp);
         chk({7'h00, d ? bus_a_oe_out : bus_b_oe_out}, 8'h01);
         drive_enable_n_a_to_b_in <= 1'b1;
         drive_enable_n_b_to_a_in <= 1'b1;
         tick(6);
         chk({6'h00, bus_a_oe_out, bus_b_oe_out}, 8'h00);
      end
   endtask
   // ==========================================
   // Scenarios
   task t_basic;
      begin
         cap(0, 8'hA5, 0);
         show(0, 8'hA5);
         cap(1, 8'h3C, 0);
         show(1, 8'h3C);
         $display("basic done");
      end
   endtask
   task t_indep;
      begin
         cap(0, 8'h0F, 1);
         show(0, 8'hA5);
         drive_enable_n_a_to_b_in <= 1'b0;
         cap(1, 8'h96, 0);
         chk(bus_b_out, 8'hA5);
         drive_enable_n_a_to_b_in <= 1'b1;
         tick(6);
         show(1, 8'h96);
         $display("independence done");
      end
   endtask
   // Queue fills while bus B stays driven, then drains once released
   task t_fill;
      begin
         drive_enable_n_a_to_b_in <= 1'b0;
         for (i = 0; i < 18; i = i + 1)
            cap(0, 8'h40 + i[7:0], 0);
         chk({7'h00, a_to_b_ready_out}, 8'h00);
         chk({3'h0, a_to_b_level_out}, 8'h10);
         chk(ovf[7:0], 8'h01);
         chk(bus_b_out, 8'hA5);
         chk({6'h00, b_to_a_ready_out, b_to_a_overflow_out}, 8'h02);
         chk({3'h0, b_to_a_level_out}, 8'h00);
         drive_enable_n_a_to_b_in <= 1'b1;
         tick(60);
         chk({3'h0, a_to_b_level_out}, 8'h00);
         show(0, 8'h50);
         $display("fill done");
      end
   endtask
   always @(posedge clk_in) begin
      cyc = cyc + 1;
      if (a_to_b_overflow_out === 1'b1)
         ovf = ovf + 1;
      if (cyc == 2000) begin
         err_total = err_total + 1;
         give_verdict;
      end
   end
   initial begin
      tick(8);
      nrst_in <= 1'b1;
      tick(4);
      t_basic;
      t_indep;
      t_fill;
      give_verdict;
   end
endmodule
bind registered_bus_transceiver registered_bus_transceiver_properties chk_i (.*);
